//--- line_unit_reset_control.sv
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
module line_unit_reset_control (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   // board pins
   input wire logic PWR_OK_I,
   input wire logic RST_N_I,
   input wire logic CLK_LOST_I,
   // axi4-lite write
   input wire logic [11:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   // axi4-lite read
   input wire logic [11:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // reset effects
   output logic DEV_RST_O,
   output logic [15:0] CH_RST_O,
   output logic [15:0] LINE_HIZ_O,
   output logic [15:0] LINE_MODE_E1_O,
   output logic [15:0] SYS_NRZ_O,
   output logic [15:0] CH_IRQ_MASKED_O,
   output logic DATA_BUS_IN_O,
   output logic [1:0] GPIO_OE_O
);
   localparam int N = reset_ctrl_pkg::NCH;
   // ==========================================================
   // synchronisers for pin and power condition
   logic pin_s1_r, pin_s2_r, pwr_s1_r, pwr_s2_r, lost_s1_r, lost_s2_r, lost_d_r;
   // pin and power release staged through two flops
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pwr_s1_r <= 1'b0;
         pwr_s2_r <= 1'b0;
         lost_s1_r <= 1'b0;
         lost_s2_r <= 1'b0;
         lost_d_r <= 1'b0;
      end else begin
         pin_s1_r <= RST_N_I; // R20
         pin_s2_r <= pin_s1_r;
         pwr_s1_r <= PWR_OK_I; // R20
         pwr_s2_r <= pwr_s1_r;
         lost_s1_r <= CLK_LOST_I;
         lost_s2_r <= lost_s1_r;
         lost_d_r <= lost_s2_r;
      end
   end
   wire logic clk_back = lost_d_r & ~lost_s2_r; // R18
   wire logic hw_hold = ~pin_s2_r | ~pwr_s2_r | lost_s2_r; // R9
   // ==========================================================
   // device reset sequencer
   reset_ctrl_pkg::dev_state_t st_r, st_nxt;
   logic [17:0] cnt_r, cnt_nxt;
   logic por_done_r, por_done_nxt;
   logic sw_req;
   // power-on counts up to half of 1 ms once powered; pin only holds
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      por_done_nxt = por_done_r;
      if (~pwr_s2_r) por_done_nxt = 1'b0;
      if (hw_hold | clk_back) begin
         st_nxt = reset_ctrl_pkg::DEV_HOLD; // R9 R18
         cnt_nxt = '0;
      end else begin
         unique case (st_r)
            reset_ctrl_pkg::DEV_HOLD: begin
               // power-on wait only once; pin release leaves at once
               if (por_done_r || cnt_r >= 18'(reset_ctrl_pkg::POR_CYC)) begin
                  st_nxt = reset_ctrl_pkg::DEV_RUN; // R8
                  por_done_nxt = 1'b1;
                  cnt_nxt = '0;
               end else cnt_nxt = cnt_r + 18'd1;
            end
            reset_ctrl_pkg::DEV_RUN: begin
               if (sw_req) begin
                  st_nxt = reset_ctrl_pkg::DEV_SWRST; // R11
                  cnt_nxt = '0;
               end
            end
            reset_ctrl_pkg::DEV_SWRST: begin
               if (cnt_r >= 18'(reset_ctrl_pkg::SW_CYC)) st_nxt = reset_ctrl_pkg::DEV_RUN; // R11
               else cnt_nxt = cnt_r + 18'd1;
            end
            default: st_nxt = reset_ctrl_pkg::DEV_HOLD;
         endcase
      end
   end
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         st_r <= reset_ctrl_pkg::DEV_HOLD;
         cnt_r <= '0;
         por_done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         por_done_r <= por_done_nxt;
      end
   end
   wire logic dev_rst = (st_nxt != reset_ctrl_pkg::DEV_RUN); // R17
   // sequencer checks; the count bound sits inside 1 ms
   a_por_bound: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R8
      cnt_r < 18'(reset_ctrl_pkg::POR_TIME_US * reset_ctrl_pkg::CLK_MHZ))
      else $error("power-on count past its ceiling");
   a_pin_hold: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R9
      hw_hold |=> DEV_RST_O)
      else $error("reset pin low but device not held");
   a_clk_return: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R18
      clk_back |=> DEV_RST_O)
      else $error("clock return did not reset device");
   a_sw_rst_done: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R11
      st_r == reset_ctrl_pkg::DEV_SWRST |-> ##[0:125] st_r != reset_ctrl_pkg::DEV_SWRST)
      else $error("global software reset overran");
   c_sw_rst: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      st_r == reset_ctrl_pkg::DEV_SWRST);
   c_clk_return: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) clk_back);
   // ==========================================================
   // axi4-lite slave, one write and one read at a time
   logic aw_ok_r, w_ok_r, bv_r, ar_r, rv_r;
   logic [11:0] awa_r, ara_r;
   logic [31:0] wd_r, rd_r;
   logic [1:0] br_r, rr_r;
   logic aw_ok_nxt, w_ok_nxt, bv_nxt, rv_nxt;
   logic [11:0] awa_nxt;
   logic [31:0] wd_nxt, rd_nxt;
   logic [1:0] br_nxt, rr_nxt;
   logic wr_go;
   logic [7:0] gcf_r, gcf_nxt;
   logic [3:0] gpio_r, gpio_nxt;
   logic [N-1:0] mode_r, mode_nxt, chrq_r, chrq_nxt;
   logic [7:0] msk_r [N], msk_nxt [N];
   logic [7:0] chc_r [N], chc_nxt [N];
   logic [N-1:0] ch_act, all_msk;
   // an item moves only on valid and ready together, as the master sees it
   wire logic aw_hs = AWVALID_I & AWREADY_O;
   wire logic w_hs = WVALID_I & WREADY_O;
   wire logic ar_hs = ARVALID_I & ARREADY_O;
   wire logic [3:0] wch = aw_hs ? AWADDR_I[5:2] : awa_r[5:2];
   // trigger decoded apart from the register process: no loop through dev_rst
   assign sw_req = (aw_ok_r | aw_hs) & (w_ok_r | w_hs)
      & ((aw_hs ? AWADDR_I : awa_r) == reset_ctrl_pkg::RST_ADDR); // R19
   wire logic [3:0] rch = ARADDR_I[5:2];
   // write path and all software-visible registers
   always_comb begin
      aw_ok_nxt = aw_ok_r | aw_hs;
      w_ok_nxt = w_ok_r | w_hs;
      awa_nxt = aw_hs ? AWADDR_I : awa_r;
      wd_nxt = w_hs ? WDATA_I : wd_r;
      bv_nxt = bv_r & ~BREADY_I;
      br_nxt = br_r;
      gcf_nxt = gcf_r;
      gpio_nxt = gpio_r;
      mode_nxt = mode_r;
      chrq_nxt = chrq_r;
      msk_nxt = msk_r;
      chc_nxt = chc_r;
      wr_go = aw_ok_nxt & w_ok_nxt;
      if (wr_go) begin
         aw_ok_nxt = 1'b0;
         w_ok_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = reset_ctrl_pkg::RESP_OKAY;
         if (awa_nxt == reset_ctrl_pkg::RST_ADDR) br_nxt = reset_ctrl_pkg::RESP_OKAY; // R19
         else if (awa_nxt == reset_ctrl_pkg::GCF_ADDR) begin
            if (WSTRB_I[0] | ~w_hs) gcf_nxt = wd_nxt[7:0];
         end else if (awa_nxt == reset_ctrl_pkg::GPIO_ADDR) gpio_nxt = wd_nxt[3:0];
         else if ({awa_nxt[11:6], 6'h00} == reset_ctrl_pkg::CH_CFG_BASE) begin
            mode_nxt[wch] = wd_nxt[reset_ctrl_pkg::MODE_BIT];
            chrq_nxt[wch] = wd_nxt[reset_ctrl_pkg::CH_SRST_BIT]; // R12
         end else if ({awa_nxt[11:6], 6'h00} == reset_ctrl_pkg::CHMSK_BASE)
            msk_nxt[wch] = wd_nxt[7:0];
         else br_nxt = reset_ctrl_pkg::RESP_SLVERR;
      end
      // channel reset: defaults but line mode kept
      for (int c = 0; c < N; c++) begin
         if (ch_act[c] && chc_r[c] >= reset_ctrl_pkg::SW_CYC_V) chrq_nxt[c] = 1'b0; // R12
         if (ch_act[c]) msk_nxt[c] = reset_ctrl_pkg::CHMSK_DEF; // R6 R14 R15
         chc_nxt[c] = ch_act[c] ? chc_r[c] + 8'd1 : 8'd0;
      end
      // device reset: everything to default, requests dropped
      if (dev_rst) begin
         gcf_nxt = reset_ctrl_pkg::GCF_DEF; // R7 R17
         gpio_nxt = reset_ctrl_pkg::GPIO_DEF; // R4
         mode_nxt = '0; // R2
         chrq_nxt = '0; // R21
         for (int c = 0; c < N; c++) msk_nxt[c] = reset_ctrl_pkg::CHMSK_DEF; // R6
      end
      // a channel counts as masked when every source mask bit is set
      for (int c = 0; c < N; c++) all_msk[c] = &msk_nxt[c]; // R6
   end
   assign ch_act = chrq_r & {N{st_r == reset_ctrl_pkg::DEV_RUN}}; // R13 R21
   // channel reset checks
   for (genvar g = 0; g < N; g++) begin : g_ch_chk
      a_ch_clear: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R12
         ch_act[g] && chc_r[g] >= reset_ctrl_pkg::SW_CYC_V |=> !chrq_r[g])
         else $error("channel reset bit not self-cleared");
   end
   a_mode_kept: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R15
      (|chrq_r) && !wr_go && !dev_rst |=> $stable(mode_r))
      else $error("channel reset changed line mode");
   a_dev_drops_req: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R21
      dev_rst |=> chrq_r == '0)
      else $error("channel request survived device reset");
   c_ch_rst: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) |ch_act);
   // read path
   always_comb begin
      rv_nxt = rv_r & ~RREADY_I;
      rd_nxt = rd_r;
      rr_nxt = rr_r;
      if (ar_hs) begin
         rv_nxt = 1'b1;
         rr_nxt = reset_ctrl_pkg::RESP_OKAY;
         rd_nxt = 32'h0000_0000;
         if (ARADDR_I == reset_ctrl_pkg::RST_ADDR) rd_nxt = 32'h0000_0000;
         else if (ARADDR_I == reset_ctrl_pkg::GCF_ADDR) rd_nxt[7:0] = gcf_r;
         else if (ARADDR_I == reset_ctrl_pkg::GPIO_ADDR) rd_nxt[3:0] = gpio_r;
         else if (ARADDR_I == reset_ctrl_pkg::STAT_ADDR) rd_nxt = {14'h0000, st_r, chrq_r};
         else if ({ARADDR_I[11:6], 6'h00} == reset_ctrl_pkg::CH_CFG_BASE)
            rd_nxt[1:0] = {chrq_r[rch], mode_r[rch]};
         else if ({ARADDR_I[11:6], 6'h00} == reset_ctrl_pkg::CHMSK_BASE)
            rd_nxt[7:0] = msk_r[rch];
         else rr_nxt = reset_ctrl_pkg::RESP_SLVERR;
      end
   end
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         aw_ok_r <= 1'b0;
         w_ok_r <= 1'b0;
         awa_r <= '0;
         wd_r <= '0;
         bv_r <= 1'b0;
         br_r <= '0;
         rv_r <= 1'b0;
         rd_r <= '0;
         rr_r <= '0;
         gcf_r <= reset_ctrl_pkg::GCF_DEF;
         gpio_r <= reset_ctrl_pkg::GPIO_DEF;
         mode_r <= '0;
         chrq_r <= '0;
         for (int c = 0; c < N; c++) begin
            msk_r[c] <= reset_ctrl_pkg::CHMSK_DEF;
            chc_r[c] <= 8'd0;
         end
      end else begin
         aw_ok_r <= aw_ok_nxt;
         w_ok_r <= w_ok_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         bv_r <= bv_nxt;
         br_r <= br_nxt;
         rv_r <= rv_nxt;
         rd_r <= rd_nxt;
         rr_r <= rr_nxt;
         gcf_r <= gcf_nxt;
         gpio_r <= gpio_nxt;
         mode_r <= mode_nxt;
         chrq_r <= chrq_nxt;
         msk_r <= msk_nxt;
         chc_r <= chc_nxt;
      end
   end
   // ==========================================================
   // registered outputs
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         AWREADY_O <= 1'b0;
         WREADY_O <= 1'b0;
         ARREADY_O <= 1'b0;
         DEV_RST_O <= 1'b1;
         CH_RST_O <= '1;
         LINE_HIZ_O <= '1;
         LINE_MODE_E1_O <= '0;
         SYS_NRZ_O <= '1;
         CH_IRQ_MASKED_O <= '1;
         DATA_BUS_IN_O <= 1'b1;
         GPIO_OE_O <= 2'b00;
      end else begin
         // ready pulses only in the cycle a handshake is possible
         AWREADY_O <= ~aw_ok_nxt & ~bv_nxt & ~AWREADY_O;
         WREADY_O <= ~w_ok_nxt & ~bv_nxt & ~WREADY_O;
         ARREADY_O <= ~rv_nxt & ~ARREADY_O;
         DEV_RST_O <= dev_rst; // R5 R17
         CH_RST_O <= {N{dev_rst}} | (chrq_nxt & {N{st_nxt == reset_ctrl_pkg::DEV_RUN}}); // R5 R14
         LINE_HIZ_O <= {N{dev_rst}} | chrq_nxt; // R1 R16
         LINE_MODE_E1_O <= mode_nxt; // R2 R15
         SYS_NRZ_O <= {N{dev_rst}} | chrq_nxt; // R3
         CH_IRQ_MASKED_O <= {N{dev_rst}} | chrq_nxt | all_msk; // R6
         DATA_BUS_IN_O <= dev_rst; // R4 R13
         GPIO_OE_O <= dev_rst ? 2'b00 : gpio_nxt[1:0]; // R4
      end
   end
   assign BVALID_O = bv_r;
   assign BRESP_O = br_r;
   assign RVALID_O = rv_r;
   assign RDATA_O = rd_r;
   assign RRESP_O = rr_r;
   // pin effects while the whole device is held
   a_dev_hiz: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R1 R3 R16
      DEV_RST_O |-> LINE_HIZ_O == 16'hffff && SYS_NRZ_O == 16'hffff)
      else $error("line pairs not tristated in device reset");
   a_dev_pins_in: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R4 R6
      DEV_RST_O |-> DATA_BUS_IN_O && GPIO_OE_O == 2'b00 && CH_IRQ_MASKED_O == 16'hffff)
      else $error("pins or masks not at reset state");
   c_pin_release: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      por_done_r && hw_hold ##1 !hw_hold);
endmodule : line_unit_reset_control

//--- reset_ctrl_pkg.sv
// What this block does
// [R1] device reset tristates all line pairs; channel only its own
// [R2] device reset returns channel line mode to T1/J1
// [R3] reset sets system interface to dual-rail NRZ
// [R4] device reset makes data and general pins inputs
// [R5] reset clears state machines of its scope
// [R6] reset masks interrupt sources of its scope
// [R7] reset loads register defaults of its scope
// [R8] power-on reset ends within 1 ms with clock
// [R9] low reset pin holds device in reset
// [R10] board holds reset pin low over 1 us
// [R11] global reset register write resets within 1 us
// [R12] channel reset bit self-clears within 1 us
// [R13] channel reset spares global logic and pins
// [R14] channel reset spares all other channels
// [R15] channel reset keeps line mode select bit
// [R16] line pairs tristated while any reset runs
// [R17] device resets cover common blocks too
// [R18] clock return after loss forces device reset
// [R19] any data written to reset register triggers
// [R20] pin and power-on release synchronised to clock
// [R21] device reset overrides a channel reset request
package reset_ctrl_pkg;
   localparam int NCH = 16;
   localparam int CLK_MHZ = 125;
   // ==========================================================
   // timing
   localparam int POR_TIME_US = 1000;
   localparam int SW_TIME_NS = 1000;
   // power-on wait is half the 1 ms ceiling, leaving margin for clock tolerance
   localparam int POR_CYC = (POR_TIME_US * CLK_MHZ) / 2 - 1;
   localparam int SW_CYC_RAW = (SW_TIME_NS * CLK_MHZ) / 1000;
   localparam int SW_CYC = SW_CYC_RAW - 4;
   localparam logic [7:0] SW_CYC_V = 8'(SW_CYC);
   // ==========================================================
   // register map: global at 0x000, channel n config at 0x100 + 4*n
   localparam logic [11:0] RST_ADDR = 12'h000;
   localparam logic [11:0] GCF_ADDR = 12'h004;
   localparam logic [11:0] GPIO_ADDR = 12'h008;
   localparam logic [11:0] STAT_ADDR = 12'h00c;
   localparam logic [11:0] CH_CFG_BASE = 12'h100;
   localparam logic [11:0] CHMSK_BASE = 12'h200;
   localparam int MODE_BIT = 0;
   localparam int CH_SRST_BIT = 1;
   localparam logic [7:0] GCF_DEF = 8'h02;
   localparam logic [3:0] GPIO_DEF = 4'h0;
   localparam logic [7:0] CHMSK_DEF = 8'hff;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      DEV_HOLD = 2'b00,
      DEV_RUN = 2'b01,
      DEV_SWRST = 2'b10
   } dev_state_t;
endpackage : reset_ctrl_pkg

//--- board_reset_model.sv
module board_reset_model (
   // clock
   input wire logic clk_i,
   // board pins
   output logic pwr_ok_o,
   output logic rst_n_o,
   output logic clk_lost_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // supplies off and pin released at start
   initial begin
      pwr_ok_o = 1'b0;
      rst_n_o = 1'b1;
      clk_lost_o = 1'b0;
   end
   // ==========================================================
   // board actions
   task automatic power_up();
      @(posedge clk_i);
      pwr_ok_o <= 1'b1;
   endtask : power_up
   // pin pulled low for cyc clocks; the 130 used here is 1.04 us, just past the 1 us minimum
   task automatic pin_reset(input int cyc);
      @(posedge clk_i);
      rst_n_o <= 1'b0;
      repeat (cyc) @(posedge clk_i);
      rst_n_o <= 1'b1;
   endtask : pin_reset
   // supervisor flags a lost clock, then recovery
   task automatic clock_loss();
      @(posedge clk_i);
      clk_lost_o <= 1'b1;
      repeat (20) @(posedge clk_i);
      clk_lost_o <= 1'b0;
   endtask : clock_loss
endmodule : board_reset_model

//--- line_unit_reset_control_tb.sv
module line_unit_reset_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, dev_rst, data_in;
   logic pwr_ok, rst_n, clk_lost;
   logic [1:0] bresp, rresp, gpio_oe, rsp;
   logic [31:0] rdata, rd;
   logic [15:0] ch_rst, hiz, e1, nrz, msk;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   always #4 mclk = ~mclk;
   line_unit_reset_control DUT (.MCLK_I(mclk), .SYS_RST_I(sys_rst), .PWR_OK_I(pwr_ok),
      .RST_N_I(rst_n), .CLK_LOST_I(clk_lost), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
      .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .DEV_RST_O(dev_rst),
      .CH_RST_O(ch_rst), .LINE_HIZ_O(hiz), .LINE_MODE_E1_O(e1), .SYS_NRZ_O(nrz),
      .CH_IRQ_MASKED_O(msk), .DATA_BUS_IN_O(data_in), .GPIO_OE_O(gpio_oe));
   board_reset_model BRD (.clk_i(mclk), .pwr_ok_o(pwr_ok), .rst_n_o(rst_n),
      .clk_lost_o(clk_lost));
   // ==========================================================
   // reporting
   task automatic test_done();
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // counts are bounds, not exact figures
   task automatic chk_max(input string nm, input int lim, input int got);
      cmp_count++;
      if (got > lim) begin
         errors++;
         $display("[ERR] %s expected <= %0d seen %0d", nm, lim, got);
      end
   endtask : chk_max
   // ==========================================================
   // bus master and waits
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge mclk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge mclk); while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rdreg(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge mclk); while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rdreg
   task automatic wt(input int c);
      repeat (c) @(posedge mclk);
   endtask : wt
   // which 0 watches device reset, 1 watches channel 3 reset
   task automatic wait_on(input int which, input logic v, input int lim);
      n = 0;
      while (((which == 0) ? dev_rst : ch_rst[3]) !== v && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask : wait_on
   // cuts a hung run short
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc > 70000) begin
         errors++;
         test_done();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      wt(2);
      sys_rst <= 1'b0;
      wt(202);
      chk("dev_rst", 32'h1, 32'(dev_rst));
      chk("hiz", 32'hffff, 32'(hiz));
      chk("e1", 32'h0, 32'(e1));
      chk("nrz", 32'hffff, 32'(nrz));
      chk("data_in", 32'h1, 32'(data_in));
      chk("gpio_oe", 32'h0, 32'(gpio_oe));
      chk("msk", 32'hffff, 32'(msk));
      BRD.power_up();
      wait_on(0, 1'b0, 125100);
      chk_max("por_time", reset_ctrl_pkg::POR_TIME_US * reset_ctrl_pkg::CLK_MHZ, n);
      chk("por_long", 32'h1, 32'(n > reset_ctrl_pkg::POR_CYC));
      rdreg(reset_ctrl_pkg::GCF_ADDR);
      chk("gcf", 32'h2, rd);
      rdreg(reset_ctrl_pkg::STAT_ADDR);
      chk("stat", 32'h0001_0000, rd);
      rdreg(12'h800);
      chk("unmapped", 32'(reset_ctrl_pkg::RESP_SLVERR), 32'(rsp));
      wr(reset_ctrl_pkg::GPIO_ADDR, 32'h3);
      wr(reset_ctrl_pkg::CH_CFG_BASE + 12'h00c, 32'h1);
      wr(reset_ctrl_pkg::CHMSK_BASE + 12'h00c, 32'h0);
      wr(reset_ctrl_pkg::CHMSK_BASE + 12'h014, 32'h0);
      wt(2);
      chk("gpio_oe", 32'h3, 32'(gpio_oe));
      chk("e1", 32'h8, 32'(e1));
      chk("msk", 32'hffd7, 32'(msk));
      // channel 3 reset with mode bit set
      wr(reset_ctrl_pkg::CH_CFG_BASE + 12'h00c, 32'h3);
      wait_on(1, 1'b1, 10);
      chk("ch_rst", 32'h8, 32'(ch_rst));
      chk("hiz3", 32'h1, 32'(hiz[3]));
      chk("dev_rst", 32'h0, 32'(dev_rst));
      chk("gpio_oe", 32'h3, 32'(gpio_oe));
      chk("e1", 32'h8, 32'(e1));
      wait_on(1, 1'b0, 125);
      chk_max("ch_time", 125, n);
      rdreg(reset_ctrl_pkg::CH_CFG_BASE + 12'h00c);
      chk("ch_cfg3", 32'h1, rd);
      chk("msk", 32'hffdf, 32'(msk));
      rdreg(reset_ctrl_pkg::CHMSK_BASE + 12'h00c);
      chk("chmsk3", 32'hff, rd);
      rdreg(reset_ctrl_pkg::CHMSK_BASE + 12'h014);
      chk("chmsk5", 32'h0, rd);
      // global reset, arbitrary nonzero data value
      wr(reset_ctrl_pkg::RST_ADDR, 32'h5a);
      wait_on(0, 1'b1, 10);
      chk("hiz", 32'hffff, 32'(hiz));
      chk("data_in", 32'h1, 32'(data_in));
      chk("gpio_oe", 32'h0, 32'(gpio_oe));
      chk("msk", 32'hffff, 32'(msk));
      chk("nrz", 32'hffff, 32'(nrz));
      chk("ch_rst", 32'hffff, 32'(ch_rst));
      wait_on(0, 1'b0, 125);
      chk_max("sw_time", 125, n);
      chk("e1", 32'h0, 32'(e1));
      rdreg(reset_ctrl_pkg::CH_CFG_BASE + 12'h00c);
      chk("ch_cfg3", 32'h0, rd);
      rdreg(reset_ctrl_pkg::GPIO_ADDR);
      chk("gpio", 32'h0, rd);
      // pin reset with a channel request while held
      fork
         BRD.pin_reset(130);
         begin
            wt(100);
            chk("dev_rst", 32'h1, 32'(dev_rst));
            wr(reset_ctrl_pkg::CH_CFG_BASE + 12'h008, 32'h2);
         end
      join
      wait_on(0, 1'b0, 20);
      chk_max("pin_release", 19, n);
      rdreg(reset_ctrl_pkg::CH_CFG_BASE + 12'h008);
      chk("ch_cfg2", 32'h0, rd);
      // clock loss and return must bring the GPIO register back to its default
      wr(reset_ctrl_pkg::GPIO_ADDR, 32'h3);
      BRD.clock_loss();
      wait_on(0, 1'b1, 10);
      chk("dev_rst", 32'h1, 32'(dev_rst));
      wait_on(0, 1'b0, 200);
      chk_max("clk_return", 199, n);
      chk("gpio_oe", 32'h0, 32'(gpio_oe));
      rdreg(reset_ctrl_pkg::GPIO_ADDR);
      chk("gpio", 32'h0, rd);
      test_done();
   end
endmodule : line_unit_reset_control_tb
